// ===== shared/servo_cmd_pkg.sv
// Constants, types and register map of the servo command and spindle block.
package servo_cmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing. Times are kept in their own units; counts derive.
  localparam int CLK_PERIOD_NS  = 4;            // Core clock period.
  localparam int CLK_HZ         = 250_000_000;  // Core clock rate.
  localparam int GLITCH_NS      = 500;          // Shortest accepted pulse.
  // Least time, so round up to whole cycles.
  localparam int GLITCH_CYC     = (GLITCH_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int PWM_HZ         = 7350;         // Velocity mode PWM rate.
  localparam int PWM_CYC        = CLK_HZ / PWM_HZ;
  localparam int FRAME_TICKS    = 588;          // Monitor ticks per frame.

  ////////////////////////////////////////////////////////////////////////////
  // Command codes.
  localparam logic [7:0] CMD_NOISE_ON  = 8'hEF;  // Filter command clock.
  localparam logic [7:0] CMD_NOISE_OFF = 8'hEE;  // Plain command clock.
  localparam logic [7:0] CMD_ACCEL     = 8'h04;  // Motor accelerate.
  localparam logic [7:0] CMD_VELOCITY  = 8'h05;  // Constant linear velocity.
  localparam logic [7:0] CMD_BRAKE     = 8'h06;  // Motor decelerate.
  localparam logic [7:0] CMD_STOP      = 8'h07;  // Motor stop.
  localparam logic [7:0] CMD_TRK_OFF   = 8'h0F;  // Tracking off.
  localparam logic [7:0] CMD_TRK_ON    = 8'h8F;  // Tracking on.

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the AXI4-Lite port.
  localparam logic [7:0] ADDR_CTRL     = 8'h00;  // Control, read/write.
  localparam logic [7:0] ADDR_STATUS   = 8'h04;  // Status, read only.
  localparam logic [7:0] ADDR_TRACKS   = 8'h08;  // Track count byte.
  localparam logic [7:0] ADDR_ATTEN    = 8'h0C;  // Attenuation/port byte.
  localparam logic [7:0] ADDR_LASTCMD  = 8'h10;  // Last command byte.
  localparam logic [7:0] DUTY_RESET    = 8'h80;  // Half duty after reset.
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Spindle motor modes.
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_ACCEL,
    MODE_VELOCITY,
    MODE_BRAKE
  } motor_mode_t;

  // Control register: bit 0 pair routing, bits 15:8 PWM duty.
  typedef struct packed {
    logic [15:0] unused;
    logic [7:0]  pwm_duty;
    logic [6:0]  spare;
    logic        pair_to_atten;
  } ctrl_reg_t;

  // Spindle drive pair.
  typedef struct packed {
    logic forward;
    logic brake;
  } spindle_drive_t;

endpackage

// ===== src/servo_command_spindle_control.sv
// Serial servo command receiver with spindle, tracking and monitor logic.
`timescale 1ns/1ns
`default_nettype none

module servo_command_spindle_control #(
  parameter int PWM_CYCLES = servo_cmd_pkg::PWM_CYC,
  parameter int FRAME_LEN  = servo_cmd_pkg::FRAME_TICKS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        command_window,
  input  wire logic        command_serial_in,
  input  wire logic        command_shift_clock,
  input  wire logic        defect_detect_in,
  input  wire logic        hf_slicer_in,
  input  wire logic        vco_clock_in,
  input  wire logic        frame_sync_in,
  output logic             spindle_forward_out,
  output logic             spindle_brake_out,
  output logic             rough_phase_out,
  output logic             tracking_off_out,
  output logic             slice_level_out,
  output logic             slice_level_oe,
  output logic             vco_half_rate_monitor,
  output logic             frame_sync_ok_monitor,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // The PWM counter and duty compare need room for a full 8-bit duty.
  if (PWM_CYCLES < 256 || PWM_CYCLES > 65536 || FRAME_LEN < 2 ||
      FRAME_LEN > 1024) begin : g_bad_params
    $error("PWM_CYCLES must be 256 to 65536 and FRAME_LEN 2 to 1024");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command receiver state.
  logic                     clk_seen;      // Registered raw shift clock.
  logic                     clk_filt;      // Clock after the noise filter.
  logic [7:0]               glitch_cnt;    // Cycles the raw level differed.
  logic                     window_q;      // Window one cycle late.
  logic [15:0]              shifter;       // Serial bits, first bit lowest.
  logic [4:0]               bit_cnt;       // Bits taken in this window.
  logic                     noise_on;      // Filter mode.
  servo_cmd_pkg::motor_mode_t mode;        // Spindle mode.
  logic                     trk_off_cmd;   // Tracking off by command.
  logic [7:0]               track_count;   // Second byte, track count.
  logic [7:0]               atten;         // Second byte, attenuation/port.
  logic [7:0]               last_cmd;      // Last decoded first byte.
  logic                     next_clk_seen, next_clk_filt, next_window_q;
  logic [7:0]               next_glitch_cnt, next_track_count;
  logic [7:0]               next_atten, next_last_cmd;
  logic [15:0]              next_shifter;
  logic [4:0]               next_bit_cnt;
  logic                     next_noise_on, next_trk_off_cmd;
  servo_cmd_pkg::motor_mode_t next_mode;
  servo_cmd_pkg::ctrl_reg_t ctrl;          // Software control register.
  logic [7:0]               first_byte;    // Byte decoded at window close.
  logic                     window_fall;   // Window just closed.

  // Clock filter, bit shifter and decoder. Inputs are already synchronous.
  always_comb begin
    next_clk_seen    = command_shift_clock;
    next_clk_filt    = clk_filt;
    next_glitch_cnt  = 8'h00;
    next_window_q    = command_window;
    next_shifter     = shifter;
    next_bit_cnt     = bit_cnt;
    next_noise_on    = noise_on;
    next_mode        = mode;
    next_trk_off_cmd = trk_off_cmd;
    next_track_count = track_count;
    next_atten       = atten;
    next_last_cmd    = last_cmd;
    window_fall      = window_q && !command_window;
    // A lone byte sits in the upper half; a pair leaves byte one low.
    first_byte = (bit_cnt == 5'd16) ? shifter[7:0] : shifter[15:8];
    // With the filter on, a level must hold 125 cycles to count, so a
    // spike under 500 ns never reaches the shifter. This costs latency.
    if (!noise_on) begin
      next_clk_filt = clk_seen;
    end else if (clk_seen != clk_filt) begin
      if (glitch_cnt == 8'(servo_cmd_pkg::GLITCH_CYC - 1)) begin
        next_clk_filt = clk_seen;
      end else begin
        next_glitch_cnt = glitch_cnt + 8'h01;
      end
    end
    // Bits are taken on rising shift clock edges inside the window.
    if (!command_window) begin
      next_bit_cnt = 5'd0;
    end else if (next_clk_filt && !clk_filt && bit_cnt != 5'd16) begin
      next_shifter = {command_serial_in, shifter[15:1]};
      next_bit_cnt = bit_cnt + 5'd1;
    end
    // Execution begins only once the window has closed.
    if (window_fall && (bit_cnt == 5'd8 || bit_cnt == 5'd16)) begin
      next_last_cmd = first_byte;
      case (first_byte)
        servo_cmd_pkg::CMD_NOISE_ON:  next_noise_on = 1'b1;
        servo_cmd_pkg::CMD_NOISE_OFF: next_noise_on = 1'b0;
        servo_cmd_pkg::CMD_ACCEL:     next_mode = servo_cmd_pkg::MODE_ACCEL;
        servo_cmd_pkg::CMD_VELOCITY:  next_mode = servo_cmd_pkg::MODE_VELOCITY;
        servo_cmd_pkg::CMD_BRAKE:     next_mode = servo_cmd_pkg::MODE_BRAKE;
        servo_cmd_pkg::CMD_STOP:      next_mode = servo_cmd_pkg::MODE_STOP;
        servo_cmd_pkg::CMD_TRK_OFF: begin
          if (mode == servo_cmd_pkg::MODE_VELOCITY) begin
            next_trk_off_cmd = 1'b1;
          end
        end
        servo_cmd_pkg::CMD_TRK_ON: begin
          if (mode == servo_cmd_pkg::MODE_VELOCITY) begin
            next_trk_off_cmd = 1'b0;
          end
        end
        default: next_last_cmd = first_byte;
      endcase
      // The second byte of a pair goes where software routes it.
      if (bit_cnt == 5'd16) begin
        if (ctrl.pair_to_atten) begin
          next_atten = shifter[15:8];
        end else begin
          next_track_count = shifter[15:8];
        end
      end
    end
  end

  // Registers of the command receiver.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_seen    <= 1'b0;
      clk_filt    <= 1'b0;
      glitch_cnt  <= 8'h00;
      window_q    <= 1'b0;
      shifter     <= 16'h0000;
      bit_cnt     <= 5'd0;
      noise_on    <= 1'b0;
      mode        <= servo_cmd_pkg::MODE_STOP;
      trk_off_cmd <= 1'b0;
      track_count <= 8'h00;
      atten       <= 8'h00;
      last_cmd    <= 8'h00;
    end else begin
      clk_seen    <= next_clk_seen;
      clk_filt    <= next_clk_filt;
      glitch_cnt  <= next_glitch_cnt;
      window_q    <= next_window_q;
      shifter     <= next_shifter;
      bit_cnt     <= next_bit_cnt;
      noise_on    <= next_noise_on;
      mode        <= next_mode;
      trk_off_cmd <= next_trk_off_cmd;
      track_count <= next_track_count;
      atten       <= next_atten;
      last_cmd    <= next_last_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spindle drive, monitors and slice level control.
  logic [31:0]                  pwm_cnt;       // Position in the PWM period.
  logic [9:0]                   frame_cnt;     // Interpolated frame timer.
  logic                         vco_q;         // VCO input one cycle late.
  logic [31:0]                  next_pwm_cnt;
  logic [9:0]                   next_frame_cnt;
  logic                         next_vco_q, next_half_rate, next_fsok;
  logic                         next_rough, next_slv, next_sloe;
  logic                         next_tracking_off;
  logic                         half_rate_tick; // Monitor clock tick.
  logic                         sync_seen;      // Sync since last tick.
  logic                         next_sync_seen;
  logic                         pwm_high;      // Duty phase of PWM.
  servo_cmd_pkg::spindle_drive_t next_drive;

  always_comb begin
    next_vco_q   = vco_clock_in;
    next_half_rate = vco_half_rate_monitor;
    next_fsok    = frame_sync_ok_monitor;
    next_pwm_cnt = (pwm_cnt == 32'(PWM_CYCLES - 1)) ? 32'h0 : pwm_cnt + 32'h1;
    next_frame_cnt = frame_cnt;
    half_rate_tick = 1'b0;
    // Each rising VCO edge toggles the monitor: divide by two.
    if (vco_clock_in && !vco_q) begin
      next_half_rate = !vco_half_rate_monitor;
      half_rate_tick = !vco_half_rate_monitor;
    end
    // A one-cycle sync is held until the next tick; a new sync wins. A
    // sync seen at the wrap tick raises the monitor for the next frame.
    next_sync_seen = frame_sync_in || (sync_seen && !half_rate_tick);
    if (half_rate_tick) begin
      if (frame_cnt == 10'(FRAME_LEN - 1)) begin
        next_frame_cnt = 10'h0;
        next_fsok      = sync_seen || frame_sync_in;
      end else begin
        next_frame_cnt = frame_cnt + 10'h1;
      end
    end
    // While unlocked a true sync realigns the interpolation counter.
    if (frame_sync_in && !frame_sync_ok_monitor && !half_rate_tick) begin
      next_frame_cnt = 10'(FRAME_LEN - 1);
    end
    // Phase control needs a running, locked clock; otherwise rough.
    next_rough = !(mode == servo_cmd_pkg::MODE_VELOCITY && next_fsok);
    pwm_high   = pwm_cnt < {16'h0, ctrl.pwm_duty, 8'h00} * 32'(PWM_CYCLES)
                 / 32'h10000;
    case (mode)
      servo_cmd_pkg::MODE_ACCEL: next_drive = '{forward: 1'b1, brake: 1'b0};
      servo_cmd_pkg::MODE_BRAKE: next_drive = '{forward: 1'b0, brake: 1'b1};
      servo_cmd_pkg::MODE_VELOCITY: begin
        // Rough servo spins up; phase control runs complementary PWM.
        if (next_rough) begin
          next_drive = '{forward: 1'b1, brake: 1'b0};
        end else begin
          next_drive = '{forward: pwm_high, brake: !pwm_high};
        end
      end
      default: next_drive = '{forward: 1'b0, brake: 1'b0};
    endcase
    next_tracking_off = (mode != servo_cmd_pkg::MODE_VELOCITY)
                        || trk_off_cmd;
    next_slv  = hf_slicer_in;
    // Floating the pin lets the external capacitor hold the slice level.
    next_sloe = !(defect_detect_in && !rough_phase_out);
  end

  // Registers of the drive and monitor group; all outputs but the AXI ones come from here.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt               <= 32'h0;
      frame_cnt             <= 10'h0;
      sync_seen             <= 1'b0;
      vco_q                 <= 1'b0;
      vco_half_rate_monitor <= 1'b0;
      frame_sync_ok_monitor <= 1'b0;
      rough_phase_out       <= 1'b1;
      spindle_forward_out   <= 1'b0;
      spindle_brake_out     <= 1'b0;
      tracking_off_out      <= 1'b1;
      slice_level_out       <= 1'b0;
      slice_level_oe        <= 1'b1;
    end else begin
      pwm_cnt               <= next_pwm_cnt;
      frame_cnt             <= next_frame_cnt;
      sync_seen             <= next_sync_seen;
      vco_q                 <= next_vco_q;
      vco_half_rate_monitor <= next_half_rate;
      frame_sync_ok_monitor <= next_fsok;
      rough_phase_out       <= next_rough;
      spindle_forward_out   <= next_drive.forward;
      spindle_brake_out     <= next_drive.brake;
      tracking_off_out      <= next_tracking_off;
      slice_level_out       <= next_slv;
      slice_level_oe        <= next_sloe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave. One write and one read at a time.
  logic        aw_full, w_full;      // Address or data already taken.
  logic [7:0]  aw_addr;              // Held write address.
  logic [31:0] w_data;               // Held write data.
  logic [3:0]  w_strb, next_w_strb;  // Lanes held with the data.
  logic        next_aw_full, next_w_full, next_bvalid, next_rvalid;
  logic        next_awready, next_wready, next_arready;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [1:0]  next_bresp, next_rresp;
  servo_cmd_pkg::ctrl_reg_t next_ctrl;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_ctrl    = ctrl;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    // Both halves present: commit and answer the next cycle.
    if (next_aw_full && next_w_full && !next_bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = servo_cmd_pkg::RESP_SLVERR;
      if ({next_aw_addr[7:2], 2'b00} == servo_cmd_pkg::ADDR_CTRL) begin
        next_bresp = servo_cmd_pkg::RESP_OKAY;
        if (next_w_strb[0]) begin
          next_ctrl.pair_to_atten = next_w_data[0];
        end
        if (next_w_strb[1]) begin
          next_ctrl.pwm_duty = next_w_data[15:8];
        end
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = servo_cmd_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        servo_cmd_pkg::ADDR_CTRL:    next_rdata = ctrl;
        servo_cmd_pkg::ADDR_STATUS:  next_rdata = {26'h0, rough_phase_out,
                                       frame_sync_ok_monitor,
                                       tracking_off_out, noise_on, mode};
        servo_cmd_pkg::ADDR_TRACKS:  next_rdata = {24'h0, track_count};
        servo_cmd_pkg::ADDR_ATTEN:   next_rdata = {24'h0, atten};
        servo_cmd_pkg::ADDR_LASTCMD: next_rdata = {24'h0, last_cmd};
        default: begin
          next_rdata = 32'h0;
          next_rresp = servo_cmd_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // Registers of the bus slave.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      ctrl          <= '{unused: 16'h0, pwm_duty: servo_cmd_pkg::DUTY_RESET,
                         spare: 7'h0, pair_to_atten: 1'b0};
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      ctrl          <= next_ctrl;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

endmodule

`default_nettype wire

// ===== verification/cmd_host_model.sv
// Controller model that shifts servo command bytes into the block.
`timescale 1ns/1ns
`default_nettype none
module cmd_host_model (
  input  wire logic aclk,
  output logic      command_window,
  output logic      command_serial_in,
  output logic      command_shift_clock
);
  // The shift clock is parked low outside frames, so no stray edge reaches it.
  initial begin
    command_window = 1'b0;
    command_serial_in = 1'b1;
    command_shift_clock = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shifts n bits LSB first; hp is the half period, gl adds short spikes.
  task automatic send(input logic [15:0] v, input int n, input int hp,
                      input bit gl);
    int i;
    @(posedge aclk);
    #1 command_window = 1'b1;
    for (i = 0; i < n; i++) begin
      command_serial_in = v[i];
      if (gl) begin
        // A 100 ns spike in the low phase, far under the filter limit.
        #(hp / 4) command_shift_clock = 1'b1;
        #100 command_shift_clock = 1'b0;
        #(hp - hp / 4 - 100);
      end else begin
        #(hp);
      end
      command_shift_clock = 1'b1;
      #(hp) command_shift_clock = 1'b0;
    end
    #(hp) command_window = 1'b0;
    // Data is no longer held, so the line shows the opposite level.
    command_serial_in = ~command_serial_in;
    repeat (12) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ===== verification/servo_cmd_chk.sv
// Port checker for the servo command and spindle block.
`timescale 1ns/1ns
`default_nettype none
module servo_cmd_chk (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic command_window,
  input  wire logic defect_detect_in,
  input  wire logic hf_slicer_in,
  input  wire logic vco_clock_in,
  input  wire logic spindle_forward_out,
  input  wire logic spindle_brake_out,
  input  wire logic rough_phase_out,
  input  wire logic tracking_off_out,
  input  wire logic slice_level_out,
  input  wire logic slice_level_oe,
  input  wire logic vco_half_rate_monitor,
  input  wire logic frame_sync_ok_monitor
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  AST_DRIVE_EXCL: assert property (
    !(spindle_forward_out && spindle_brake_out)) else $error("both drives high");
  AST_RESET_STATE: assert property ($rose(aresetn) |-> tracking_off_out &&
    rough_phase_out && !spindle_forward_out && !spindle_brake_out)
    else $error("outputs not at reset state");
  // Mode outputs must not move while bits are still shifting in.
  AST_WINDOW_QUIET: assert property (command_window[*4] |->
    $stable(tracking_off_out) && $stable(rough_phase_out))
    else $error("output moved inside window");
  AST_SLICE_FLOAT: assert property (
    defect_detect_in && !rough_phase_out |=> !slice_level_oe)
    else $error("slice output driven on defect");
  AST_SLICE_DRIVE: assert property (
    !defect_detect_in |=> slice_level_oe) else $error("slice output floats");
  AST_SLICE_COPY: assert property ($past(aresetn) && slice_level_oe |->
    slice_level_out == $past(hf_slicer_in)) else $error("slice value wrong");
  AST_HALF_RATE_FOLLOW: assert property ($rose(vco_clock_in) |->
    ##[1:4] $changed(vco_half_rate_monitor)) else $error("monitor missed edge");
  AST_HALF_RATE_STILL: assert property ($stable(vco_clock_in)[*6] |->
    $stable(vco_half_rate_monitor)) else $error("monitor moved alone");
  // Main scenarios that should be reached.
  cover property (!rough_phase_out && defect_detect_in);
  cover property ($rose(frame_sync_ok_monitor));
  cover property (spindle_brake_out && !tracking_off_out);
endmodule
bind servo_command_spindle_control servo_cmd_chk u_chk (.*);
`default_nettype wire

// ===== verification/test_servo_command_spindle_control.sv
// Self-checking bench for the servo command and spindle block.
`timescale 1ns/1ns
`default_nettype none
module test_servo_command_spindle_control;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic             defect_detect_in = 1'b0, hf_slicer_in = 1'b0;
  logic             vco_clock_in = 1'b0, frame_sync_in = 1'b0;
  logic             sync_en = 1'b0;         // Starts the frame sync source.
  logic [7:0]       cnt = 8'h00;            // Free count for line patterns.
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic [3:0]       s_axi_wstrb = 4'hF;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic             s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic             s_axi_rready = 1'b0;
  logic [1:0]       seen;                   // PWM levels observed.
  wire logic        command_window, command_serial_in, command_shift_clock;
  wire logic        spindle_forward_out, spindle_brake_out, rough_phase_out;
  wire logic        tracking_off_out, slice_level_out, slice_level_oe;
  wire logic        vco_half_rate_monitor, frame_sync_ok_monitor;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic        s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int               num_errors = 0, cmp_count = 0, i;
  logic [7:0]       cd[4] = '{8'h04, 8'h06, 8'h07, 8'h05};
  logic [2:0]       dv[4] = '{3'b101, 3'b011, 3'b001, 3'b100};
  logic [1:0]       md[4] = '{2'h1, 2'h3, 2'h0, 2'h2};
  localparam logic [1:0] OK = servo_cmd_pkg::RESP_OKAY;
  localparam logic [1:0] ER = servo_cmd_pkg::RESP_SLVERR;
  // Short counts keep the PWM period and frame small.
  servo_command_spindle_control #(.PWM_CYCLES(256), .FRAME_LEN(4)) u_dut (.*);
  cmd_host_model u_host (.*);
  always #2 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  // Line patterns; the VCO stays still until locking is wanted.
  always @(posedge aclk) begin
    cnt <= cnt + 8'h01;
    vco_clock_in <= sync_en & cnt[2];
    frame_sync_in <= sync_en && cnt[5:0] == 6'h3F;
    defect_detect_in <= cnt[4];
    hf_slicer_in <= cnt[1] ^ cnt[3];
  end
  task automatic finish_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // A wait that ran out is reported and ends the run.
  task automatic timeout;
    num_errors++;
    $display("[ERR] handshake expected done seen timeout");
    finish_test;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e);
    bit aw, w, b;
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    for (t = 0; t < 64 && !b; t++) begin
      @(posedge aclk);
      b = s_axi_bvalid;
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1'b0;
    if (!b) timeout();
    chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    bit ar, r;
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar = 1'b1;
    r = 1'b0;
    for (t = 0; t < 64 && !r; t++) begin
      @(posedge aclk);
      r = s_axi_rvalid;
      ar = ar && !s_axi_arready;
      s_axi_arvalid <= ar;
    end
    s_axi_rready <= 1'b0;
    if (!r) timeout();
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // Sends a command, then compares forward, brake and tracking-off.
  task automatic cmd(input logic [15:0] v, input int n, input int hp,
                     input bit gl, input logic [2:0] e);
    u_host.send(v, n, hp, gl);
    chk("drive", {29'h0, e}, {29'h0, spindle_forward_out, spindle_brake_out,
        tracking_off_out});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(servo_cmd_pkg::ADDR_CTRL, 32'h8000, OK);
    axi_rd(servo_cmd_pkg::ADDR_STATUS, 32'h28, OK);
    cmd(16'h0F, 8, 40, 0, 3'b001);
    for (i = 0; i < 4; i++) begin
      cmd({8'h0, cd[i]}, 8, 40, 0, dv[i]);
      axi_rd(servo_cmd_pkg::ADDR_STATUS, {26'h0, 2'b10, dv[i][0], 1'b0, md[i]},
             OK);
    end
    cmd(16'h0F, 8, 40, 0, 3'b101);
    cmd(16'h8F, 8, 40, 0, 3'b100);
    cmd(16'h33, 8, 40, 0, 3'b100);
    axi_rd(servo_cmd_pkg::ADDR_LASTCMD, 32'h33, OK);
    cmd(16'h07, 7, 40, 0, 3'b100);
    cmd(16'h5A05, 16, 40, 0, 3'b100);
    axi_rd(servo_cmd_pkg::ADDR_TRACKS, 32'h5A, OK);
    axi_wr(servo_cmd_pkg::ADDR_CTRL, 32'h8001, OK);
    cmd(16'hC305, 16, 40, 0, 3'b100);
    axi_rd(servo_cmd_pkg::ADDR_ATTEN, 32'hC3, OK);
    axi_rd(servo_cmd_pkg::ADDR_TRACKS, 32'h5A, OK);
    cmd(16'hEF, 8, 40, 0, 3'b100);
    axi_rd(servo_cmd_pkg::ADDR_STATUS, 32'h26, OK);
    cmd(16'h04, 8, 1200, 1, 3'b101);
    cmd(16'hEE, 8, 1200, 0, 3'b101);
    // Unfiltered spikes double every bit, so 06 arrives as 3C.
    cmd(16'h06, 8, 200, 1, 3'b101);
    axi_rd(servo_cmd_pkg::ADDR_LASTCMD, 32'h3C, OK);
    cmd(16'h06, 8, 40, 0, 3'b011);
    axi_rd(servo_cmd_pkg::ADDR_STATUS, 32'h2B, OK);
    axi_rd(8'h20, 32'h0, ER);
    axi_wr(servo_cmd_pkg::ADDR_STATUS, 32'hFFFF, ER);
    axi_rd(servo_cmd_pkg::ADDR_CTRL, 32'h8001, OK);
    s_axi_wstrb <= 4'h2;
    axi_wr(servo_cmd_pkg::ADDR_CTRL, 32'h4000, OK);
    axi_rd(servo_cmd_pkg::ADDR_CTRL, 32'h4001, OK);
    cmd(16'h05, 8, 40, 0, 3'b100);
    sync_en <= 1'b1;
    for (i = 0; i < 3000 && rough_phase_out !== 1'b0; i++) @(posedge aclk);
    chk("rough_sync", 32'h1, {30'h0, rough_phase_out, frame_sync_ok_monitor});
    seen = 2'b00;
    for (i = 0; i < 300; i++) begin
      @(posedge aclk);
      seen = seen | {spindle_forward_out, spindle_brake_out};
    end
    chk("pwm", 32'h3, {30'h0, seen});
    finish_test;
  end
endmodule
`default_nettype wire
